//--- logic/mrc_defs.vh
/*
 constants for the mode-set host: register offsets, field positions,
 reset values and timing counts.
 assumes a 10 MHz system clock and a memory clock made by dividing it.
*/
`ifndef MRC_DEFS_VH
`define MRC_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define MRC_OFF_CTRL 5'h00
`define MRC_OFF_FIRST 5'h04
`define MRC_OFF_SECOND 5'h08
`define MRC_OFF_THIRD 5'h0c
`define MRC_OFF_STATUS 5'h10
`define MRC_OFF_LAT 5'h14

// ------------------------------------------------------------
// control register bits
// ------------------------------------------------------------
`define MRC_CTL_GO_FIRST 0
`define MRC_CTL_GO_SECOND 1
`define MRC_CTL_LOCK_RESET 2
`define MRC_CTL_GO_THIRD 3
`define MRC_CTL_ODT_REQ 8
`define MRC_CTL_RTT_WRITES 9

// ------------------------------------------------------------
// configuration field positions
// ------------------------------------------------------------
`define MRC_F1_BL 0
`define MRC_F1_BT 2
`define MRC_F1_CL 3
`define MRC_F1_WR 7
`define MRC_F1_PD 10
`define MRC_F2_DLLOFF 0
`define MRC_F2_DRV 1
`define MRC_F2_RTT 3
`define MRC_F2_AL 6
`define MRC_F2_WLVL 8
`define MRC_F2_TERMINATION_STROBE 9
`define MRC_F2_QOFF 10
`define MRC_F3_PASR 0
`define MRC_F3_CWL 3
`define MRC_F3_ASR 6
`define MRC_F3_SRT 7
`define MRC_F3_RTTWR 8

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define MRC_CFG_RST 11'h000
`define MRC_CTL_RST 2'h0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define MRC_SYS_PERIOD_NS 100
`define MRC_CLK_DIV 4
`define MRC_T_WR_NS 15
`define MRC_MRD_NCK 10'h004
`define MRC_LOCK_NCK 10'h200

`endif

//--- logic/mrc_clkdiv.v
/*
 memory clock divider: square clock out and a one-cycle tick that
 lands on the cycle before the falling edge of that clock.
 assumes a divide ratio of four on the single system clock.
*/
`include "mrc_defs.vh"

module mrc_clkdiv (
    input wire i_clk,
    input wire i_rst_n,
    output reg o_mem_clk,
    output reg o_tick
);

    reg [1:0] cnt_r;
    wire [1:0] cnt_nxt;

    assign cnt_nxt = cnt_r + 2'h1;

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    // clock is high in counts 2 and 3; tick sits in count 3 so pins
    // move with the falling edge, half a period before the device samples
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_r <= 2'h0;
            o_mem_clk <= 1'b0;
            o_tick <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            o_mem_clk <= cnt_nxt[1];
            o_tick <= (cnt_nxt == 2'h3);
        end
    end

endmodule

//--- logic/mrc_host.v
/*
 mode-set host: takes orders over a small register port and writes the
 first, second and third mode registers of a synchronous dram.
 assumes the device samples pins on the rising edge of o_mem_clk and
 that software waits for the busy flag before changing configuration.
*/
`include "mrc_defs.vh"

module mrc_host (
    input wire i_clk,
    input wire i_rst_n,
    input wire [4:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    output wire o_mem_clk,
    output reg o_cke,
    output reg o_cs_n,
    output reg o_ras_n,
    output reg o_cas_n,
    output reg o_we_n,
    output reg [2:0] o_ba,
    output reg [14:0] o_maddr,
    output reg o_odt,
    output reg o_read_ok
);

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_CMD = 2'h1;
    localparam ST_GAP = 2'h2;
    localparam ST_LOCK = 2'h3;
    localparam integer TCK_NS = `MRC_SYS_PERIOD_NS * `MRC_CLK_DIV;
    localparam integer WR_MIN = (`MRC_T_WR_NS + TCK_NS - 1) / TCK_NS;
    localparam [9:0] MRD_CNT = `MRC_MRD_NCK - 10'h001;
    localparam [9:0] LOCK_CNT = `MRC_LOCK_NCK - 10'h001;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg [1:0] state_r;
    reg [9:0] wait_r;
    reg [3:0] pend_r;
    reg [1:0] ctl_r;
    reg [10:0] cfg1_r;
    reg [10:0] cfg2_r;
    reg [10:0] cfg3_r;
    reg dll_off_r;
    reg [1:0] err_r;
    wire tick;
    wire wr_hit_ctrl;
    wire wr_hit_status;
    wire [3:0] go_set;
    wire busy;
    wire [4:0] cl_cyc;
    wire [4:0] cwl_cyc;
    reg [5:0] al_cyc;
    wire [5:0] rl_cyc;
    wire [5:0] wl_cyc;
    wire first_ok;
    wire second_ok;
    wire new_off;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function [4:0] wr_cycles;
        input [2:0] code;
        begin
            case (code)
                3'h1: wr_cycles = 5'h05;
                3'h2: wr_cycles = 5'h06;
                3'h3: wr_cycles = 5'h07;
                3'h4: wr_cycles = 5'h08;
                3'h5: wr_cycles = 5'h0a;
                3'h6: wr_cycles = 5'h0c;
                3'h7: wr_cycles = 5'h0e;
                default: wr_cycles = 5'h10;
            endcase
        end
    endfunction

    // only disabled, RZQ/4, RZQ/2 and RZQ/6 codes have a clear top bit
    function rtt_safe;
        input [2:0] code;
        begin
            rtt_safe = ~code[2];
        end
    endfunction

    function [14:0] first_addr;
        input [10:0] c;
        input lock_rst;
        begin
            first_addr = 15'h0000;
            first_addr[1:0] = c[`MRC_F1_BL +: 2];
            first_addr[3] = c[`MRC_F1_BT];
            first_addr[2] = c[`MRC_F1_CL];
            first_addr[6:4] = c[`MRC_F1_CL + 1 +: 3];
            first_addr[7] = 1'b0;
            first_addr[8] = lock_rst;
            first_addr[11:9] = c[`MRC_F1_WR +: 3];
            first_addr[12] = c[`MRC_F1_PD];
        end
    endfunction

    function [14:0] second_addr;
        input [10:0] c;
        reg [2:0] rtt;
        begin
            second_addr = 15'h0000;
            rtt = c[`MRC_F2_DLLOFF] ? 3'h0 : c[`MRC_F2_RTT +: 3];
            second_addr[0] = c[`MRC_F2_DLLOFF];
            second_addr[1] = c[`MRC_F2_DRV];
            second_addr[5] = c[`MRC_F2_DRV + 1];
            second_addr[2] = rtt[0];
            second_addr[6] = rtt[1];
            second_addr[9] = rtt[2];
            second_addr[4:3] = c[`MRC_F2_AL +: 2];
            second_addr[7] = c[`MRC_F2_WLVL];
            second_addr[11] = c[`MRC_F2_TERMINATION_STROBE];
            second_addr[12] = c[`MRC_F2_QOFF];
        end
    endfunction

    function [14:0] third_addr;
        input [10:0] c;
        input off;
        begin
            third_addr = 15'h0000;
            third_addr[2:0] = c[`MRC_F3_PASR +: 3];
            third_addr[5:3] = c[`MRC_F3_CWL +: 3];
            third_addr[6] = c[`MRC_F3_ASR];
            third_addr[7] = c[`MRC_F3_SRT];
            // write termination stays on with nominal off, unless lock loop is off
            third_addr[10:9] = off ? 2'h0 : c[`MRC_F3_RTTWR +: 2];
        end
    endfunction

    // ------------------------------------------------------------
    // clock divider
    // ------------------------------------------------------------
    mrc_clkdiv u_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .o_mem_clk(o_mem_clk),
        .o_tick(tick)
    );

    // ------------------------------------------------------------
    // checks and latencies
    // ------------------------------------------------------------
    assign wr_hit_ctrl = i_wr && (i_addr == `MRC_OFF_CTRL);
    assign wr_hit_status = i_wr && (i_addr == `MRC_OFF_STATUS);
    assign go_set = wr_hit_ctrl ? {i_wdata[`MRC_CTL_LOCK_RESET], i_wdata[`MRC_CTL_GO_THIRD],
        i_wdata[`MRC_CTL_GO_SECOND], i_wdata[`MRC_CTL_GO_FIRST]} : 4'h0;
    assign busy = (state_r != ST_IDLE) || (pend_r != 4'h0);
    assign new_off = cfg2_r[`MRC_F2_DLLOFF];

    assign first_ok = (wr_cycles(cfg1_r[`MRC_F1_WR +: 3]) >= WR_MIN);
    assign second_ok = (cfg2_r[`MRC_F2_AL +: 2] != 2'h3)
        && (new_off || rtt_safe(cfg2_r[`MRC_F2_RTT +: 3])
        || !((cfg2_r[`MRC_F2_WLVL] && !cfg2_r[`MRC_F2_QOFF]) || ctl_r[1]));

    assign cl_cyc = cfg1_r[`MRC_F1_CL] ? {2'h0, cfg1_r[`MRC_F1_CL + 1 +: 3]} + 5'h0c
        : {2'h0, cfg1_r[`MRC_F1_CL + 1 +: 3]} + 5'h04;
    assign cwl_cyc = {2'h0, cfg3_r[`MRC_F3_CWL +: 3]} + 5'h05;

    always @*
    begin
        case (cfg2_r[`MRC_F2_AL +: 2])
            2'h1: al_cyc = {1'b0, cl_cyc - 5'h01};
            2'h2: al_cyc = {1'b0, cl_cyc - 5'h02};
            default: al_cyc = 6'h00;
        endcase
    end

    assign rl_cyc = al_cyc + {1'b0, cl_cyc};
    assign wl_cyc = al_cyc + {1'b0, cwl_cyc};

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctl_r <= `MRC_CTL_RST;
            cfg1_r <= `MRC_CFG_RST;
            cfg2_r <= `MRC_CFG_RST;
            cfg3_r <= `MRC_CFG_RST;
            o_rdata <= 32'h00000000;
        end
        else
        begin
            if (wr_hit_ctrl)
            begin
                ctl_r <= {i_wdata[`MRC_CTL_RTT_WRITES], i_wdata[`MRC_CTL_ODT_REQ]};
            end
            if (i_wr && (i_addr == `MRC_OFF_FIRST))
            begin
                cfg1_r <= i_wdata[10:0];
            end
            if (i_wr && (i_addr == `MRC_OFF_SECOND))
            begin
                cfg2_r <= i_wdata[10:0];
            end
            if (i_wr && (i_addr == `MRC_OFF_THIRD))
            begin
                cfg3_r <= i_wdata[10:0];
            end
            if (i_rd)
            begin
                case (i_addr)
                    `MRC_OFF_CTRL: o_rdata <= {22'h0, ctl_r, 8'h00};
                    `MRC_OFF_FIRST: o_rdata <= {21'h0, cfg1_r};
                    `MRC_OFF_SECOND: o_rdata <= {21'h0, cfg2_r};
                    `MRC_OFF_THIRD: o_rdata <= {21'h0, cfg3_r};
                    `MRC_OFF_STATUS: o_rdata <= {26'h0, err_r, 1'b0, dll_off_r, (state_r == ST_LOCK), busy};
                    `MRC_OFF_LAT: o_rdata <= {18'h0, wl_cyc, 2'h0, rl_cyc};
                    default: o_rdata <= 32'h00000000;
                endcase
            end
            else
            begin
                o_rdata <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    // pend bits: 0 first, 1 second, 2 third, 3 first with lock reset.
    // a refused write drops its pending bit and raises a sticky error;
    // a new order in the cycle a bit is consumed is kept (set wins).
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= ST_IDLE;
            wait_r <= 10'h000;
            pend_r <= 4'h0;
            dll_off_r <= 1'b0;
            err_r <= 2'h0;
            o_cke <= 1'b0;
            o_cs_n <= 1'b1;
            o_ras_n <= 1'b1;
            o_cas_n <= 1'b1;
            o_we_n <= 1'b1;
            o_ba <= 3'h0;
            o_maddr <= 15'h0000;
            o_odt <= 1'b0;
            o_read_ok <= 1'b0;
        end
        else
        begin
            pend_r <= pend_r | go_set;
            if (wr_hit_status)
            begin
                err_r <= err_r & ~i_wdata[5:4];
            end
            o_cke <= 1'b1;
            o_read_ok <= (state_r != ST_LOCK) && !busy;
            o_odt <= ctl_r[0] && !dll_off_r && !busy;
            if (tick)
            begin
                case (state_r)
                    ST_IDLE:
                    begin
                        if (pend_r[1])
                        begin
                            pend_r <= (pend_r & 4'hd) | go_set
                                | {!new_off && dll_off_r, new_off && !dll_off_r, 2'h0};
                            if (second_ok)
                            begin
                                {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= 4'h0;
                                o_ba <= 3'h1;
                                o_maddr <= second_addr(cfg2_r);
                                dll_off_r <= new_off;
                                state_r <= ST_CMD;
                            end
                            else
                            begin
                                pend_r <= (pend_r & 4'hd) | go_set;
                                err_r[1] <= 1'b1;
                            end
                        end
                        else if (pend_r[2])
                        begin
                            pend_r <= (pend_r & 4'hb) | go_set;
                            {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= 4'h0;
                            o_ba <= 3'h2;
                            o_maddr <= third_addr(cfg3_r, dll_off_r);
                            state_r <= ST_CMD;
                        end
                        else if (pend_r[3] || pend_r[0])
                        begin
                            pend_r <= (pend_r[3] ? (pend_r & 4'h7) : (pend_r & 4'he)) | go_set;
                            if (first_ok)
                            begin
                                {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= 4'h0;
                                o_ba <= 3'h0;
                                o_maddr <= first_addr(cfg1_r, pend_r[3]);
                                state_r <= ST_CMD;
                                wait_r <= pend_r[3] ? LOCK_CNT : MRD_CNT;
                            end
                            else
                            begin
                                err_r[0] <= 1'b1;
                            end
                        end
                        if (!pend_r[3] || pend_r[1] || pend_r[2])
                        begin
                            wait_r <= MRD_CNT;
                        end
                    end
                    ST_CMD:
                    begin
                        // one memory clock of command, then deselect
                        o_cs_n <= 1'b1;
                        o_ras_n <= 1'b1;
                        o_cas_n <= 1'b1;
                        o_we_n <= 1'b1;
                        o_maddr <= 15'h0000;
                        o_ba <= 3'h0;
                        state_r <= (wait_r == LOCK_CNT) ? ST_LOCK : ST_GAP;
                    end
                    ST_GAP:
                    begin
                        if (wait_r == 10'h000)
                        begin
                            state_r <= ST_IDLE;
                        end
                        else
                        begin
                            wait_r <= wait_r - 10'h001;
                        end
                    end
                    ST_LOCK:
                    begin
                        // no command at all until the lock loop settles
                        if (wait_r == 10'h000)
                        begin
                            state_r <= ST_IDLE;
                        end
                        else
                        begin
                            wait_r <= wait_r - 10'h001;
                        end
                    end
                    default:
                    begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

//--- test/mrc_host_properties.sv
/* checker on the pins of the mode-set host.
   assumes it is bound to mrc_host and sees its ports only. */
`include "mrc_defs.vh"
module mrc_host_props (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic o_cke,
    input wire logic o_cs_n,
    input wire logic o_ras_n,
    input wire logic o_cas_n,
    input wire logic o_we_n,
    input wire logic [2:0] o_ba,
    input wire logic [14:0] o_maddr,
    input wire logic o_odt,
    input wire logic o_read_ok
);
    // ----
    // helpers
    // ----
    localparam int LOCK_CYC = `MRC_LOCK_NCK * `MRC_CLK_DIV;
    logic cs_q;
    logic off_r;
    logic [11:0] lock_cnt;
    wire cmd = !o_cs_n && !o_ras_n && !o_cas_n && !o_we_n;
    wire go = cmd && cs_q;
    wire [2:0] term = {o_maddr[9], o_maddr[6], o_maddr[2]};
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // counts from command start, so it undershoots the real wait on purpose
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cs_q <= 1'b1;
            off_r <= 1'b0;
            lock_cnt <= 12'h000;
        end
        else
        begin
            cs_q <= o_cs_n;
            if (go && o_ba == 3'h0 && o_maddr[8])
                lock_cnt <= LOCK_CYC[11:0];
            else if (lock_cnt != 12'h000)
                lock_cnt <= lock_cnt - 12'h001;
            if (go && o_ba == 3'h1)
                off_r <= o_maddr[0];
        end
    end
    property p_first_rsv;
        cmd && o_ba == 3'h0 |-> !o_maddr[7] && o_maddr[14:13] == 2'h0;
    endproperty
    a_first_rsv: assert property (p_first_rsv) else $error("first register reserved bits set");
    property p_second_rsv;
        cmd && o_ba == 3'h1 |-> !o_maddr[8] && !o_maddr[10] && o_maddr[14:13] == 2'h0;
    endproperty
    a_second_rsv: assert property (p_second_rsv) else $error("second register reserved bits set");
    property p_cmd_len;
        $fell(o_cs_n) |-> (cmd && !o_ba[2])[*4] ##1 (o_cs_n && o_ras_n && o_cas_n && o_we_n);
    endproperty
    a_cmd_len: assert property (p_cmd_len) else $error("mode-set command shape wrong");
    property p_lock_wait;
        lock_cnt != 12'h000 |-> !o_read_ok && !o_odt;
    endproperty
    a_lock_wait: assert property (p_lock_wait) else $error("read or odt allowed in lock wait");
    property p_cke;
        lock_cnt != 12'h000 |-> o_cke;
    endproperty
    a_cke: assert property (p_cke) else $error("clock gate low in lock wait");
    property p_off_odt;
        off_r |-> !o_odt;
    endproperty
    a_off_odt: assert property (p_off_odt) else $error("odt high with lock loop off");
    property p_off_third;
        cmd && o_ba == 3'h2 && off_r |-> o_maddr[10:9] == 2'h0;
    endproperty
    a_off_third: assert property (p_off_third) else $error("write termination on with lock off");
    property p_relock;
        go && o_ba == 3'h1 && !o_maddr[0] && off_r |-> ##[4:200] (go && o_ba == 3'h0 && o_maddr[8]);
    endproperty
    a_relock: assert property (p_relock) else $error("lock enable not followed by reset");
    property p_wlvl;
        cmd && o_ba == 3'h1 && o_maddr[7] && !o_maddr[12] |-> term < 3'h4;
    endproperty
    a_wlvl: assert property (p_wlvl) else $error("bad termination in leveling");
    c_lock: cover property (go && o_ba == 3'h0 && o_maddr[8]);
    c_third: cover property (go && o_ba == 3'h2);
    c_wlvl: cover property (go && o_ba == 3'h1 && o_maddr[7]);
endmodule
bind mrc_host mrc_host_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .o_cke(o_cke), .o_cs_n(o_cs_n),
    .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n), .o_ba(o_ba), .o_maddr(o_maddr), .o_odt(o_odt),
    .o_read_ok(o_read_ok));

//--- test/mrc_dev_model.sv
/* memory device model: mode registers and their decode.
   assumes pins are sampled on the rising memory clock. */
module mrc_dev_model (
    input wire logic i_mem_clk,
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic [2:0] i_ba,
    input wire logic [14:0] i_maddr
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // mode registers
    // ----
    logic [14:0] mr_first = 15'h0000;
    logic [14:0] mr_second = 15'h0000;
    logic [14:0] mr_third = 15'h0000;
    int n_cmds = 0;
    int n_lock_rst = 0;
    logic test_mode = 1'b0;
    logic [4:0] wr_recovery;
    wire set = i_cke && !i_cs_n && !i_ras_n && !i_cas_n && !i_we_n;
    always @(posedge i_mem_clk)
    begin
        if (set)
            n_cmds <= n_cmds + 1;
        if (set && i_ba == 3'h0) // reset request bit never sticks
            mr_first <= {i_maddr[14:9], 1'b0, i_maddr[7:0]};
        if (set && i_ba == 3'h0 && i_maddr[8])
            n_lock_rst <= n_lock_rst + 1;
        if (set && i_ba == 3'h0 && i_maddr[7])
            test_mode <= 1'b1;
        if (set && i_ba == 3'h1)
            mr_second <= i_maddr;
        if (set && i_ba == 3'h2)
            mr_third <= i_maddr;
    end
    wire [5:0] read_col_lat = {3'h0, mr_first[6:4]} + (mr_first[2] ? 6'h0c : 6'h04);
    wire [5:0] posted = (mr_second[4:3] == 2'h1) ? read_col_lat - 6'h01 :
        (mr_second[4:3] == 2'h2) ? read_col_lat - 6'h02 : 6'h00;
    wire [5:0] total_read_lat = posted + read_col_lat;
    wire [5:0] total_write_lat = posted + {3'h0, mr_third[5:3]} + 6'h05;
    wire fast_exit = mr_first[12];
    wire lock_on = !mr_second[0]; // self refresh not modelled
    wire [1:0] drive_sel = {mr_second[5], mr_second[1]};
    wire outputs_off = mr_second[12];
    wire strobe_on = mr_second[11];
    wire [1:0] write_term = mr_third[10:9];
    always_comb
        case (mr_first[11:9])
            3'h0: wr_recovery = 5'h10;
            3'h5: wr_recovery = 5'h0a;
            3'h6: wr_recovery = 5'h0c;
            3'h7: wr_recovery = 5'h0e;
            default: wr_recovery = {2'h0, mr_first[11:9]} + 5'h04;
        endcase
endmodule

//--- test/mrc_host_test.sv
/* bench for the mode-set host: register port in, pins judged by a device model.
   assumes the design header is on the include path. */
`include "mrc_defs.vh"
module mrc_host_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rst_n, i_wr, i_rd, o_mem_clk, o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n, o_odt, o_read_ok;
    logic [4:0] i_addr;
    logic [31:0] i_wdata, o_rdata, ctl_lvl;
    logic [2:0] o_ba;
    logic [14:0] o_maddr;
    int fails, n_checks;
    mrc_host dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_mem_clk(o_mem_clk), .o_cke(o_cke), .o_cs_n(o_cs_n),
        .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n), .o_ba(o_ba), .o_maddr(o_maddr),
        .o_odt(o_odt), .o_read_ok(o_read_ok));
    mrc_dev_model u_dev (.i_mem_clk(o_mem_clk), .i_cke(o_cke), .i_cs_n(o_cs_n), .i_ras_n(o_ras_n),
        .i_cas_n(o_cas_n), .i_we_n(o_we_n), .i_ba(o_ba), .i_maddr(o_maddr));
    // ----
    // helpers
    // ----
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask
    // waits out pending commands and any lock wait; n counts the cycles
    task automatic go(input logic [4:0] off, input logic [31:0] cfg, input int b, output int n);
        wr(off, cfg);
        wr(`MRC_OFF_CTRL, ctl_lvl | (32'h1 << b));
        n = 0;
        repeat (3) @(negedge i_clk);
        while (o_read_ok !== 1'b1 && n < 3000)
        begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 3000)
            fails++;
    endtask
    function automatic logic [14:0] exp_first(input logic [10:0] c);
        return {2'h0, c[10], c[9:7], 2'h0, c[6:4], c[2], c[3], c[1:0]};
    endfunction
    function automatic logic [14:0] exp_second(input logic [10:0] c);
        return {2'h0, c[10], c[9], 1'b0, c[5], 1'b0, c[8], c[4], c[2], c[7], c[6], c[3], c[1], c[0]};
    endfunction
    function automatic logic [5:0] cl_of(input logic [10:0] c);
        return {3'h0, c[6:4]} + (c[3] ? 6'h0c : 6'h04);
    endfunction
    function automatic logic [4:0] wrc(input logic [2:0] k);
        logic [4:0] t [8] = '{5'h10, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0a, 5'h0c, 5'h0e};
        return t[k];
    endfunction
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        logic [31:0] v;
        rd(`MRC_OFF_STATUS, v);
        chk("status", v, 32'h0);
        chk("cke", o_cke, 1'b1);
        rd(5'h18, v);
        chk("unmapped", v, 32'h0);
        rd(`MRC_OFF_LAT, v);
        chk("lat", v, 32'h0504);
    endtask
    task automatic t_first;
        logic [31:0] v;
        logic [10:0] c;
        int n;
        for (int i = 0; i < 2; i++)
        begin
            c = (i == 0) ? 11'h5d5 : 11'h01a;
            go(`MRC_OFF_FIRST, {21'h0, c}, `MRC_CTL_GO_FIRST, n);
            chk("first pins", u_dev.mr_first, exp_first(c));
            chk("recovery", u_dev.wr_recovery, wrc(c[9:7]));
            chk("exit", u_dev.fast_exit, c[10]);
            rd(`MRC_OFF_LAT, v);
            chk("read lat", v[5:0], cl_of(c));
        end
    endtask
    task automatic t_second;
        logic [31:0] v;
        logic [10:0] c;
        logic [5:0] al;
        int n;
        go(`MRC_OFF_THIRD, 32'h110, `MRC_CTL_GO_THIRD, n);
        chk("third pins", u_dev.mr_third, 15'h0210);
        for (int i = 0; i < 3; i++)
        begin
            c = 11'(i << 6) | 11'(i << 1) | 11'((i & 1) << 9) | 11'((i & 2) << 7) | 11'h008;
            al = (i == 0) ? 6'h00 : 6'(13 - i);
            go(`MRC_OFF_SECOND, {21'h0, c}, `MRC_CTL_GO_SECOND, n);
            chk("second pins", u_dev.mr_second, exp_second(c));
            chk("drive", u_dev.drive_sel, c[2:1]);
            chk("strobe", u_dev.strobe_on, c[9]);
            chk("dev lat", u_dev.total_read_lat, al + 6'h0d);
            rd(`MRC_OFF_LAT, v);
            chk("lat", v, {18'h0, al + 6'h07, 2'h0, al + 6'h0d});
        end
    endtask
    task automatic t_refuse;
        logic [31:0] v;
        logic [10:0] c [3] = '{11'h0c0, 11'h128, 11'h020};
        int k;
        int n;
        for (int i = 0; i < 3; i++)
        begin
            ctl_lvl = (i == 2) ? 32'h200 : 32'h0;
            k = u_dev.n_cmds;
            go(`MRC_OFF_SECOND, {21'h0, c[i]}, `MRC_CTL_GO_SECOND, n);
            chk("refused", u_dev.n_cmds - k, 32'h0);
            rd(`MRC_OFF_STATUS, v);
            chk("refused flag", v[5], 1'b1);
            wr(`MRC_OFF_STATUS, 32'h20);
        end
        ctl_lvl = 32'h0;
        go(`MRC_OFF_SECOND, 32'h528, `MRC_CTL_GO_SECOND, n);
        chk("outputs off", u_dev.outputs_off, 1'b1);
        rd(`MRC_OFF_STATUS, v);
        chk("flag clear", v, 32'h0);
    endtask
    task automatic t_lockoff;
        logic [31:0] v;
        int k;
        int n;
        ctl_lvl = 32'h100;
        wr(`MRC_OFF_THIRD, 32'h310);
        k = u_dev.n_cmds;
        go(`MRC_OFF_SECOND, 32'h011, `MRC_CTL_GO_SECOND, n);
        chk("off cmds", u_dev.n_cmds - k, 32'h2);
        chk("off second", u_dev.mr_second, exp_second(11'h001));
        chk("off third", u_dev.write_term, 2'h0);
        chk("off odt", o_odt, 1'b0);
        chk("lock on", u_dev.lock_on, 1'b0);
        rd(`MRC_OFF_STATUS, v);
        chk("off status", v[2], 1'b1);
        k = u_dev.n_lock_rst;
        go(`MRC_OFF_SECOND, 32'h010, `MRC_CTL_GO_SECOND, n);
        chk("relock", u_dev.n_lock_rst - k, 32'h1);
        chk("lock wait", n >= 2048, 1'b1);
        chk("reset bit", u_dev.mr_first[8], 1'b0);
        chk("cke", o_cke, 1'b1);
        @(negedge i_clk);
        chk("odt", o_odt, 1'b1);
        chk("test mode", u_dev.test_mode, 1'b0);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial
    begin
        #2000000;
        fails++;
        end_sim;
    end
    initial
    begin
        fails = 0;
        n_checks = 0;
        ctl_lvl = 32'h0;
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 5'h00;
        i_wdata = 32'h0;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        t_reset;
        t_first;
        t_second;
        t_refuse;
        t_lockoff;
        end_sim;
    end
endmodule
